// [sbd_host.sv]
/* host end: axi4-lite command and status registers driving the register link
   assumes an axi4-lite master on CLK and the device end on the link */
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module sbd_host
    import sbd_pkg::*;
(
    input  wire logic                  CLK,
    input  wire logic                  NRST,
    input  wire logic                  CE,
    input  wire logic                  AWVALID,
    output logic                       AWREADY,
    input  wire logic [AXI_ADDR_W-1:0] AWADDR,
    input  wire logic                  WVALID,
    output logic                       WREADY,
    input  wire logic [31:0]           WDATA,
    input  wire logic [3:0]            WSTRB,
    output logic                       BVALID,
    input  wire logic                  BREADY,
    output logic      [1:0]            BRESP,
    input  wire logic                  ARVALID,
    output logic                       ARREADY,
    input  wire logic [AXI_ADDR_W-1:0] ARADDR,
    output logic                       RVALID,
    input  wire logic                  RREADY,
    output logic      [31:0]           RDATA,
    output logic      [1:0]            RRESP,
    sbd_link.host                      LINK
);

    sbd_hstate_e state_reg;
    sbd_op_e     op_reg;
    sbd_op_e     c_op;
    logic        req_reg;
    logic        banked_reg;
    logic [7:0]  addr_reg;
    logic [7:0]  wdata_reg;
    logic [7:0]  data_hi_reg;
    logic        word_reg;
    logic        phase_reg;
    logic [1:0]  bank_reg;
    logic [15:0] rword_reg;
    logic        refused_reg;
    logic        awready_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        arready_reg;
    logic        rvalid_reg;
    logic [1:0]  rresp_reg;
    logic [31:0] rdata_reg;
    logic [7:0]  c_lin;
    logic        c_mac;
    logic        c_word;
    logic        c_bad;
    logic        is_cmd;
    logic        cmd_go;

    // command check before issue
    always_comb begin
        c_op = sbd_op_e'(WDATA[CMD_OP_LSB +: 3]);
        c_word = WDATA[CMD_WORD];
        c_lin = sbd_alias(sbd_linear(WDATA[CMD_BANKED], bank_reg, WDATA[7:0]));
        c_mac = sbd_is_mac(c_lin);
        c_bad = (WDATA[CMD_OP_LSB +: 3] > OP_BANK) || (WSTRB != 4'hf);
        c_bad = c_bad || (c_mac && (c_op == OP_SET || c_op == OP_CLR));
        c_bad = c_bad || (c_mac && c_op == OP_WR && (!c_word || c_lin[0]));
        c_bad = c_bad || (c_word && c_op != OP_RD && c_op != OP_WR);
        is_cmd = (AWADDR == ADDR_CMD);
        cmd_go = awready_reg && is_cmd && state_reg == H_IDLE && !c_bad;
    end

    // axi write channel
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            awready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            refused_reg <= 1'b0;
        end else if (CE) begin
            awready_reg <= !awready_reg && !bvalid_reg && AWVALID && WVALID;
            if (awready_reg) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= (cmd_go || AWADDR == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
                if (is_cmd) begin
                    refused_reg <= !cmd_go;
                end
            end else if (BREADY) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // link sequencer; a word goes low byte then high byte, the high byte request raised the cycle after the low byte's ack
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg <= H_IDLE;
            req_reg <= 1'b0;
            op_reg <= OP_RD;
            banked_reg <= 1'b0;
            addr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            data_hi_reg <= 8'h00;
            word_reg <= 1'b0;
            phase_reg <= 1'b0;
            bank_reg <= 2'h0;
            rword_reg <= 16'h0000;
        end else if (CE) begin
            case (state_reg)
                H_IDLE: begin
                    if (cmd_go) begin
                        state_reg <= H_WAIT;
                        req_reg <= 1'b1;
                        op_reg <= c_op;
                        banked_reg <= WDATA[CMD_BANKED];
                        addr_reg <= WDATA[7:0];
                        wdata_reg <= WDATA[CMD_DATA_LSB +: 8];
                        data_hi_reg <= WDATA[CMD_DATA_LSB + 8 +: 8];
                        word_reg <= c_word;
                        phase_reg <= 1'b0;
                        if (c_op == OP_BANK) begin
                            bank_reg <= WDATA[CMD_DATA_LSB +: 2];
                        end
                    end
                end
                H_WAIT: begin
                    req_reg <= 1'b0;
                    if (LINK.ack && word_reg && !phase_reg) begin
                        phase_reg <= 1'b1;
                        req_reg <= 1'b1;
                        addr_reg <= 8'(addr_reg + 8'h01);
                        wdata_reg <= data_hi_reg;
                        rword_reg[7:0] <= LINK.rdata;
                    end else if (LINK.ack) begin
                        state_reg <= H_IDLE;
                        if (word_reg) begin
                            rword_reg[15:8] <= LINK.rdata;
                        end else begin
                            rword_reg <= {8'h00, LINK.rdata};
                        end
                    end
                end
                default: begin
                    state_reg <= H_IDLE;
                end
            endcase
        end
    end

    // axi read channel
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h00000000;
        end else if (CE) begin
            arready_reg <= !arready_reg && !rvalid_reg && ARVALID;
            if (arready_reg) begin
                rvalid_reg <= 1'b1;
                rresp_reg <= (ARADDR == ADDR_STATUS || ARADDR == ADDR_CMD) ?
                             RESP_OKAY : RESP_SLVERR;
                rdata_reg <= (ARADDR == ADDR_STATUS) ?
                             {rword_reg, 14'h0000, refused_reg, state_reg == H_WAIT} :
                             32'h00000000;
            end else if (RREADY) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    assign AWREADY = awready_reg;
    assign WREADY = awready_reg;
    assign BVALID = bvalid_reg;
    assign BRESP = bresp_reg;
    assign ARREADY = arready_reg;
    assign RVALID = rvalid_reg;
    assign RRESP = rresp_reg;
    assign RDATA = rdata_reg;
    assign LINK.req = req_reg;
    assign LINK.op = op_reg;
    assign LINK.banked = banked_reg;
    assign LINK.addr = addr_reg;
    assign LINK.wdata = wdata_reg;

endmodule

// [sbd_pkg.sv]
/* constants, types and address helpers for the register link
   assumes nothing of its surroundings */
package sbd_pkg;

    localparam int         NUM_WORDS      = 80;
    localparam logic [15:0] REG_RESET     = 16'h0000;
    localparam logic [4:0]  COMMON_LO     = 5'h16;
    localparam logic [7:0]  UNBANKED_BASE = 8'h80;
    localparam logic [7:0]  MAC_A_BASE    = 8'h40;
    localparam logic [7:0]  MAC_A_END     = 8'h54;
    localparam logic [7:0]  MAC_B_BASE    = 8'h60;
    localparam logic [7:0]  MAC_B_END     = 8'h6c;
    localparam logic [7:0]  RSV_A_BASE    = 8'h4c;
    localparam logic [7:0]  RSV_A_END     = 8'h52;
    localparam logic [7:0]  RSV_B_BASE    = 8'h92;

    localparam logic [7:0] A_TX_START_POINTER      = 8'h00;
    localparam logic [7:0] A_TX_LENGTH             = 8'h02;
    localparam logic [7:0] A_RX_BUFFER_START       = 8'h04;
    localparam logic [7:0] A_RX_TAIL_POINTER       = 8'h06;
    localparam logic [7:0] A_RX_HEAD_POINTER       = 8'h08;
    localparam logic [7:0] A_DMA_SOURCE_POINTER    = 8'h0a;
    localparam logic [7:0] A_DMA_LENGTH            = 8'h0c;
    localparam logic [7:0] A_DMA_DEST_POINTER      = 8'h0e;
    localparam logic [7:0] A_DMA_CHECKSUM          = 8'h10;
    localparam logic [7:0] A_TX_STATUS_VECTOR      = 8'h12;
    localparam logic [7:0] A_USER_AREA_START       = 8'h16;
    localparam logic [7:0] A_USER_AREA_END         = 8'h18;
    localparam logic [7:0] A_GLOBAL_STATUS         = 8'h1a;
    localparam logic [7:0] A_IRQ_FLAGS             = 8'h1c;
    localparam logic [7:0] A_CONTROL_ONE           = 8'h1e;
    localparam logic [7:0] A_HASH_FILTER_WORD1     = 8'h20;
    localparam logic [7:0] A_HASH_FILTER_WORD2     = 8'h22;
    localparam logic [7:0] A_HASH_FILTER_WORD3     = 8'h24;
    localparam logic [7:0] A_HASH_FILTER_WORD4     = 8'h26;
    localparam logic [7:0] A_PATTERN_MASK_WORD1    = 8'h28;
    localparam logic [7:0] A_PATTERN_MASK_WORD2    = 8'h2a;
    localparam logic [7:0] A_PATTERN_MASK_WORD3    = 8'h2c;
    localparam logic [7:0] A_PATTERN_MASK_WORD4    = 8'h2e;
    localparam logic [7:0] A_PATTERN_CHECKSUM      = 8'h30;
    localparam logic [7:0] A_PATTERN_OFFSET        = 8'h32;
    localparam logic [7:0] A_MAC_CONTROL_ONE       = 8'h40;
    localparam logic [7:0] A_MAC_CONTROL_TWO       = 8'h42;
    localparam logic [7:0] A_BACK_TO_BACK_GAP      = 8'h44;
    localparam logic [7:0] A_INTER_PACKET_GAP      = 8'h46;
    localparam logic [7:0] A_COLLISION_CONTROL     = 8'h48;
    localparam logic [7:0] A_MAX_FRAME_LENGTH      = 8'h4a;
    localparam logic [7:0] A_PHY_MGMT_COMMAND      = 8'h52;
    localparam logic [7:0] A_STATION_ADDR_WORD3    = 8'h60;
    localparam logic [7:0] A_STATION_ADDR_WORD2    = 8'h62;
    localparam logic [7:0] A_STATION_ADDR_WORD1    = 8'h64;
    localparam logic [7:0] A_PHY_MGMT_WRITE_DATA   = 8'h66;
    localparam logic [7:0] A_PHY_MGMT_READ_DATA    = 8'h68;
    localparam logic [7:0] A_PHY_MGMT_STATUS       = 8'h6a;
    localparam logic [7:0] A_PAUSE_TIMER_VALUE     = 8'h6c;
    localparam logic [7:0] A_CONTROL_TWO           = 8'h6e;
    localparam logic [7:0] A_RX_WATERMARK          = 8'h70;
    localparam logic [7:0] A_IRQ_ENABLE_MASK       = 8'h72;
    localparam logic [7:0] A_GENERAL_DATA_WINDOW   = 8'h80;
    localparam logic [7:0] A_RX_DATA_WINDOW        = 8'h82;
    localparam logic [7:0] A_USER_DATA_WINDOW      = 8'h84;
    localparam logic [7:0] A_GENERAL_READ_POINTER  = 8'h86;
    localparam logic [7:0] A_GENERAL_WRITE_POINTER = 8'h88;
    localparam logic [7:0] A_RX_READ_POINTER       = 8'h8a;
    localparam logic [7:0] A_RX_WRITE_POINTER      = 8'h8c;
    localparam logic [7:0] A_USER_READ_POINTER     = 8'h8e;
    localparam logic [7:0] A_USER_WRITE_POINTER    = 8'h90;

    localparam int         AXI_ADDR_W  = 4;
    localparam logic [3:0] ADDR_CMD    = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam int         CMD_OP_LSB  = 8;
    localparam int         CMD_BANKED  = 11;
    localparam int         CMD_WORD    = 12;
    localparam int         CMD_DATA_LSB = 16;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        OP_RD   = 3'h0,
        OP_WR   = 3'h1,
        OP_SET  = 3'h2,
        OP_CLR  = 3'h3,
        OP_BANK = 3'h4
    } sbd_op_e;

    typedef enum logic [1:0] {
        H_IDLE = 2'b01,
        H_WAIT = 2'b10
    } sbd_hstate_e;

    function automatic logic [7:0] sbd_linear(input logic banked, input logic [1:0] bank,
                                              input logic [7:0] addr);
        return banked ? {1'b0, bank, addr[4:0]} : addr;
    endfunction

    function automatic logic [7:0] sbd_alias(input logic [7:0] a);
        return (a < UNBANKED_BASE && a[4:0] >= COMMON_LO) ? {3'b000, a[4:0]} : a;
    endfunction

    function automatic logic sbd_is_mac(input logic [7:0] a);
        return (a >= MAC_A_BASE && a < MAC_A_END) || (a >= MAC_B_BASE && a < MAC_B_END);
    endfunction

    function automatic logic sbd_implemented(input logic [7:0] a);
        return a < RSV_B_BASE && !(a >= RSV_A_BASE && a < RSV_A_END)
               && !(a > A_GENERAL_DATA_WINDOW && a <= A_USER_DATA_WINDOW && a[0]);
    endfunction

endpackage

// [sbd_link.sv]
/* byte-wide register link between host end and device end
   assumes both ends share CLK */
`timescale 1ns/1ps
interface sbd_link
    import sbd_pkg::*;
();
    logic       req;
    sbd_op_e    op;
    logic       banked;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       ack;
    logic [7:0] rdata;

    modport dev  (input req, op, banked, addr, wdata, output ack, rdata);
    modport host (output req, op, banked, addr, wdata, input ack, rdata);
endinterface

// [sbd_device.sv]
/* device end: banked and unbanked decode, common aliases, register bank,
   mac word commit
   assumes the host sends one-cycle requests and waits for ack between them */
`timescale 1ns/1ps
module sbd_device
    import sbd_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        NRST,
    input  wire logic        CE,
    input  wire logic [15:0] STATUS_IN,
    output logic      [15:0] CTRL_ONE,
    output logic      [1:0]  BANK,
    output logic             MAC_COMMIT,
    output logic      [7:0]  MAC_COMMIT_ADDR,
    sbd_link.dev             LINK
);

    // storage and link answer
    logic [15:0] mem [0:NUM_WORDS-1];
    logic [1:0]  bank_reg;
    logic        ack_reg;
    logic [7:0]  rdata_reg;

    // mac pairing
    logic [7:0]  lo_hold_reg;
    logic [6:0]  lo_word_reg;
    logic        lo_valid_reg;

    // user-side copies
    logic [15:0] ctrl_one_reg;
    logic        commit_reg;
    logic [7:0]  commit_addr_reg;

    // decode
    logic [7:0]  lin;
    logic [7:0]  eff;
    logic [6:0]  widx;
    logic        hi;
    logic        impl;
    logic        mac;
    logic        is_status;
    logic        is_write;
    logic        is_bitop;
    logic        is_read;
    logic        pair_ok;

    // byte merge and write
    logic [15:0] old_word;
    logic [7:0]  old_byte;
    logic [7:0]  new_byte;
    logic [15:0] wr_word;
    logic        wr_en;
    logic        mac_commit;

    // address decode
    always_comb begin
        lin = sbd_linear(LINK.banked, bank_reg, LINK.addr);
        eff = sbd_alias(lin);
        widx = eff[7:1];
        hi = eff[0];
        impl = sbd_implemented(eff);
        mac = sbd_is_mac(eff);
        is_status = (widx == A_GLOBAL_STATUS[7:1]);
        is_write = (LINK.op == OP_WR);
        is_bitop = (LINK.op == OP_SET) || (LINK.op == OP_CLR);
        is_read = (LINK.op == OP_RD);
        pair_ok = lo_valid_reg && (lo_word_reg == widx);
    end

    // byte merge
    always_comb begin
        old_word = 16'h0000;
        if (is_status) begin
            old_word = STATUS_IN;
        end else if (impl) begin
            old_word = mem[widx];
        end
        old_byte = hi ? old_word[15:8] : old_word[7:0];
        // bit ops change only the addressed byte
        case (LINK.op)
            OP_SET: begin
                new_byte = old_byte | LINK.wdata;
            end
            OP_CLR: begin
                new_byte = old_byte & ~LINK.wdata;
            end
            default: begin
                new_byte = LINK.wdata;
            end
        endcase
    end

    // write enable and word to store
    always_comb begin
        wr_word = hi ? {new_byte, old_word[7:0]} : {old_word[15:8], new_byte};
        wr_en = 1'b0;
        mac_commit = 1'b0;
        // status is read-only; unimplemented locations drop writes
        if (LINK.req && impl && !is_status) begin
            if (!mac) begin
                wr_en = is_write || is_bitop;
            end else if (is_write && hi && pair_ok) begin
                wr_en = 1'b1;
                mac_commit = 1'b1;
                wr_word = {LINK.wdata, lo_hold_reg};
            end
        end
    end

    // register storage, one word per entry
    for (genvar i = 0; i < NUM_WORDS; i++) begin : g_word
        always_ff @(posedge CLK or negedge NRST) begin
            if (!NRST) begin
                mem[i] <= REG_RESET;
            end else if (CE && wr_en && widx == 7'(i)) begin
                mem[i] <= wr_word;
            end
        end
    end

    // mac low-byte holding latch; any other request drops it
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            lo_valid_reg <= 1'b0;
            lo_hold_reg <= 8'h00;
            lo_word_reg <= 7'h00;
        end else if (CE && LINK.req) begin
            lo_valid_reg <= mac && impl && is_write && !hi;
            lo_hold_reg <= LINK.wdata;
            lo_word_reg <= widx;
        end
    end

    // bank select
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            bank_reg <= 2'h0;
        end else if (CE && LINK.req && LINK.op == OP_BANK) begin
            bank_reg <= LINK.wdata[1:0];
        end
    end

    // answer one cycle after each request
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ack_reg <= 1'b0;
        end else if (CE) begin
            ack_reg <= LINK.req;
        end
    end

    // read byte; zero for other ops, held until the next request
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_reg <= 8'h00;
        end else if (CE && LINK.req) begin
            if (is_read) begin
                rdata_reg <= old_byte;
            end else begin
                rdata_reg <= 8'h00;
            end
        end
    end

    // control word copy for the user side
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_one_reg <= REG_RESET;
        end else if (CE) begin
            ctrl_one_reg <= mem[A_CONTROL_ONE[7:1]];
        end
    end

    // mac commit pulse and the word it landed in
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            commit_reg <= 1'b0;
            commit_addr_reg <= 8'h00;
        end else if (CE) begin
            commit_reg <= mac_commit;
            if (mac_commit) begin
                commit_addr_reg <= {widx, 1'b0};
            end
        end
    end

    // outputs straight from flops
    assign LINK.ack = ack_reg;
    assign LINK.rdata = rdata_reg;
    assign CTRL_ONE = ctrl_one_reg;
    assign BANK = bank_reg;
    assign MAC_COMMIT = commit_reg;
    assign MAC_COMMIT_ADDR = commit_addr_reg;

endmodule

// [sbd_checker.sv]
/* link checker: request/answer timing, mac word pairing, read data rules
   assumes it is instantiated in tb beside the link joining both ends */
`timescale 1ns/1ps
module sbd_checker
    import sbd_pkg::*;
(
    input wire logic       CLK,
    input wire logic       NRST,
    input wire logic       req,
    input wire sbd_op_e    op,
    input wire logic       banked,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       ack,
    input wire logic [7:0] rdata
);
    logic is_mac;

    // documented mac locations only
    assign is_mac = (addr >= 8'h40 && addr < 8'h4c) || addr == 8'h52 || addr == 8'h53
                    || (addr >= 8'h60 && addr < 8'h6c);

    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    ack_after_req_a: assert property (req |=> ack && !req)
        else $error("no ack one cycle after request");
    ack_has_cause_a: assert property (ack |-> $past(req))
        else $error("ack without request");
    ack_one_cycle_a: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    mac_no_bitop_a: assert property (
        req && !banked && (op == OP_SET || op == OP_CLR) |-> !is_mac)
        else $error("bit operation sent to mac register");
    mac_low_high_a: assert property (
        req && !banked && op == OP_WR && is_mac && !addr[0]
        |-> ##2 req && op == OP_WR && addr == ($past(addr, 2) | 8'h01))
        else $error("mac low byte not followed by its high byte");
    mac_high_alone_a: assert property (
        req && !banked && op == OP_WR && is_mac && addr[0]
        |-> $past(req, 2) && $past(addr, 2) == (addr & 8'hfe))
        else $error("mac high byte without its low byte");
    write_rdata_zero_a: assert property (ack && $past(op) != OP_RD |-> rdata == 8'h00)
        else $error("read data not zero after non-read");
    rdata_holds_a: assert property (!ack |-> $stable(rdata))
        else $error("read data changed without ack");
    unimpl_zero_a: assert property (
        ack && $past(op) == OP_RD && !$past(banked)
        && ($past(addr) inside {[8'h4c:8'h51], [8'h92:8'hff]}) |-> rdata == 8'h00)
        else $error("unimplemented location read nonzero");

    cover property (req && op == OP_BANK);
    cover property (req && op == OP_SET);
    cover property (req && banked && op == OP_WR);
endmodule

// [tb.sv]
/* self-checking bench: axi4-lite master on the host end, host and device
   joined by the link; assumes sbd_pkg, sbd_link, sbd_host, sbd_device */
`timescale 1ns/1ps
module tb
    import sbd_pkg::*;
;
    logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, mac_commit;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [1:0]  bresp, rresp, bank;
    logic [31:0] wdata, rdata, seed, v, w;
    logic [15:0] status_in, ctrl_one;
    logic [7:0]  mac_addr;
    logic [31:0] exp_q[$], msk_q[$];
    int          miscompares, compares, n_commit;

    sbd_link link ();
    sbd_host sbd_host_inst (.CLK(clk), .NRST(nrst), .CE(1'b1), .AWVALID(awvalid),
        .AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata),
        .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
        .ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata),
        .RRESP(rresp), .LINK(link));
    sbd_device sbd_device_inst (.CLK(clk), .NRST(nrst), .CE(1'b1), .STATUS_IN(status_in),
        .CTRL_ONE(ctrl_one), .BANK(bank), .MAC_COMMIT(mac_commit),
        .MAC_COMMIT_ADDR(mac_addr), .LINK(link));
    sbd_checker sbd_checker_inst (.CLK(clk), .NRST(nrst), .req(link.req), .op(link.op),
        .banked(link.banked), .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
        .rdata(link.rdata));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        if (miscompares == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic note(input logic [31:0] d, input logic [31:0] m);
        exp_q.push_back(d);
        msk_q.push_back(m);
    endtask

    task automatic take(input logic [31:0] got);
        if (exp_q.size() == 0) check(got, 32'hx);
        else check(got & msk_q.pop_front(), exp_q.pop_front());
    endtask

    // results are paired with the oldest note
    always @(posedge clk) begin
        if (bvalid && bready) take({30'h0, bresp});
        if (rvalid && rready) begin
            take(rdata);
            take({30'h0, rresp});
        end
    end

    always @(posedge clk) if (mac_commit) n_commit++;

    task automatic limit(input int n);
        if (n >= 50) begin
            check(32'h1, 32'h0);
            stop_test();
        end
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int  n;
        logic aw, wd;
        @(posedge clk);
        note({30'h0, r}, 32'h3);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        bready <= 1'b1;
        aw = 1'b0;
        wd = 1'b0;
        for (n = 0; n < 50 && !(aw && wd); n++) begin
            @(posedge clk);
            if (awready) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        limit(n);
        n = 0;
        do @(posedge clk); while (!bvalid && ++n < 50);
        bready <= 1'b0;
        limit(n);
    endtask

    task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m,
                          input logic [1:0] r);
        int n;
        @(posedge clk);
        note(d, m);
        note({30'h0, r}, 32'h3);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        n = 0;
        do @(posedge clk); while (!arready && ++n < 50);
        arvalid <= 1'b0;
        limit(n);
        n = 0;
        do @(posedge clk); while (!rvalid && ++n < 50);
        rready <= 1'b0;
        limit(n);
    endtask

    // link command, then the fixed link walk runs out
    task automatic cmd(input sbd_op_e op, input logic bk, input logic wd, input logic [7:0] a,
                       input logic [15:0] d, input logic [1:0] r);
        axi_wr(ADDR_CMD, {d, 3'h0, wd, bk, op, a}, r);
        repeat (6) @(posedge clk);
    endtask

    task automatic rd(input logic bk, input logic wd, input logic [7:0] a, input logic [15:0] e);
        cmd(OP_RD, bk, wd, a, 16'h0000, RESP_OKAY);
        axi_rd(ADDR_STATUS, {e, 16'h0000}, 32'hffff0001, RESP_OKAY);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        n_commit = 0;
        seed = 32'd76;
        v = rnd();
        status_in = v[15:0];
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        axi_rd(ADDR_STATUS, 32'h0, 32'hffffffff, RESP_OKAY);
        axi_rd(4'h8, 32'h0, 32'hffffffff, RESP_SLVERR);
        axi_wr(4'hc, 32'h0, RESP_SLVERR);
        rd(1'b0, 1'b1, A_TX_LENGTH, 16'h0000);
        v = rnd();
        cmd(OP_WR, 1'b0, 1'b0, 8'h13, {8'h00, v[15:8]}, RESP_OKAY);
        cmd(OP_WR, 1'b0, 1'b0, 8'h12, {8'h00, v[7:0]}, RESP_OKAY);
        rd(1'b0, 1'b1, A_TX_STATUS_VECTOR, v[15:0]);
        rd(1'b0, 1'b0, 8'h13, {8'h00, v[15:8]});
        for (int b = 0; b < 4; b++) begin
            v = rnd();
            cmd(OP_BANK, 1'b0, 1'b0, 8'h00, {14'h0, b[1:0]}, RESP_OKAY);
            check({30'h0, bank}, b);
            cmd(OP_WR, 1'b1, 1'b1, 8'h0a, v[15:0], RESP_OKAY);
            rd(1'b0, 1'b1, {1'b0, b[1:0], 5'h0a}, v[15:0]);
        end
        check(n_commit, 2);
        check({24'h0, mac_addr}, 32'h6a);
        v = rnd();
        cmd(OP_WR, 1'b1, 1'b1, 8'h16, v[15:0], RESP_OKAY);
        rd(1'b0, 1'b1, A_USER_AREA_START, v[15:0]);
        rd(1'b0, 1'b1, 8'h36, v[15:0]);
        cmd(OP_WR, 1'b0, 1'b1, 8'h5a, ~status_in, RESP_OKAY);
        rd(1'b1, 1'b1, 8'h1a, status_in);
        w = rnd();
        cmd(OP_WR, 1'b1, 1'b1, 8'h1e, w[15:0], RESP_OKAY);
        check({16'h0, ctrl_one}, {16'h0, w[15:0]});
        cmd(OP_WR, 1'b0, 1'b1, A_GENERAL_READ_POINTER, v[15:0], RESP_OKAY);
        rd(1'b0, 1'b1, 8'h86, v[15:0]);
        rd(1'b1, 1'b1, 8'h86, 16'h0000);
        cmd(OP_WR, 1'b0, 1'b0, 8'h92, v[15:0], RESP_OKAY);
        rd(1'b0, 1'b0, 8'h92, 16'h0000);
        rd(1'b0, 1'b0, 8'h4c, 16'h0000);
        cmd(OP_WR, 1'b0, 1'b0, 8'h20, 16'h000f, RESP_OKAY);
        cmd(OP_SET, 1'b0, 1'b0, 8'h20, 16'h00f0, RESP_OKAY);
        rd(1'b0, 1'b0, 8'h20, 16'h00ff);
        cmd(OP_CLR, 1'b0, 1'b0, 8'h20, 16'h003c, RESP_OKAY);
        rd(1'b0, 1'b0, 8'h20, 16'h00c3);
        cmd(OP_SET, 1'b0, 1'b0, A_MAC_CONTROL_ONE, 16'h00ff, RESP_SLVERR);
        cmd(OP_WR, 1'b0, 1'b0, 8'h41, 16'h00ff, RESP_SLVERR);
        wstrb <= 4'h3;
        cmd(OP_WR, 1'b0, 1'b1, A_TX_LENGTH, 16'hffff, RESP_SLVERR);
        wstrb <= 4'hf;
        rd(1'b0, 1'b1, A_TX_LENGTH, 16'h0000);
        cmd(OP_WR, 1'b0, 1'b1, A_MAC_CONTROL_ONE, w[31:16], RESP_OKAY);
        rd(1'b0, 1'b1, 8'h40, w[31:16]);
        check(n_commit, 3);
        check({24'h0, mac_addr}, 32'h40);
        stop_test();
    end
endmodule
